/* src/lfp_target.sv */
/*
 * LPC flash target port: decodes host cycles on the nibble lines, returns
 * read bytes with fixed wait syncs and passes writes to the guard.
 * Assumes the LPC clock is far slower than clk (4+ clk per half period);
 * the array is read outside through rd_req / rd_data.
 */
`include "lfp_cfg.svh"

module lfp_target (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        lpc_clk,
    input  wire logic        lframe_n,
    input  wire logic [3:0]  lad_in,
    output logic      [3:0]  lad_out,
    output logic             lad_oe,
    input  wire logic        interface_reset_n,
    input  wire logic        cpu_reset_n,
    input  wire logic        top_block_lock_n,
    input  wire logic        main_block_protect_n,
    input  wire logic        program_supply_lockout_level,
    output logic             rd_req,
    output logic             rd_array,
    output logic      [18:0] rd_addr,
    input  wire logic [7:0]  rd_data,
    input  wire logic        pe_busy,
    input  wire logic        err_clear,
    output logic             pe_cmd_valid,
    output logic             pe_cmd_array,
    output logic      [18:0] pe_cmd_addr,
    output logic      [7:0]  pe_cmd_data,
    output logic             pe_abort,
    output logic             supply_err,
    output logic      [7:0]  lock_bits,
    output logic             in_reset
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and LPC clock edge

    logic [10:0] pins_s;
    logic        lclk_s;
    logic        frame_n_s;
    logic [3:0]  lad_s;
    logic        irst_n_s;
    logic        crst_n_s;
    logic        tbl_n_s;
    logic        wp_n_s;
    logic        vpp_s;
    logic        lclk_d_q;
    logic        dev_rst;
    logic        adv;
    logic [31:0] addr_nx;

    lfp_pkg::lfp_core_t c_q;
    lfp_pkg::lfp_core_t c_d;

    lfp_sync #(
        .W (11)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({lpc_clk, lframe_n, lad_in, interface_reset_n, cpu_reset_n,
               top_block_lock_n, main_block_protect_n, program_supply_lockout_level}),
        .q   (pins_s)
    );

    assign {lclk_s, frame_n_s, lad_s, irst_n_s, crst_n_s, tbl_n_s, wp_n_s, vpp_s} = pins_s;

    // Clock, frame and data share one synchroniser depth, so the
    // sampled nibble stays aligned with the detected rising edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lclk_d_q <= 1'b0;
        end else begin
            lclk_d_q <= lclk_s;
        end
    end

    assign dev_rst = !irst_n_s || !crst_n_s;
    assign adv     = lclk_s && !lclk_d_q && !dev_rst;
    assign addr_nx = {c_q.addr[27:0], lad_s};

    ////////////////////////////////////////////////////////////////////////
    // Cycle sequencer

    always_comb begin
        c_d         = c_q;
        c_d.rd_req  = 1'b0;
        c_d.cmd_stb = 1'b0;
        if (dev_rst) begin
            // Leaves the sequencer idle and floated: read mode on release
            c_d = '0;
        end else if (adv) begin
            if (!frame_n_s) begin
                // Frame low always restarts; anything but a start is skipped
                c_d.st = (lad_s == `LFP_NIB_START) ? lfp_pkg::ST_CTYPE : lfp_pkg::ST_SKIP;
            end else begin
                unique case (c_q.st)
                    lfp_pkg::ST_IDLE, lfp_pkg::ST_SKIP: begin
                        c_d.st = c_q.st;
                    end
                    lfp_pkg::ST_CTYPE: begin
                        if (lad_s[3:2] == `LFP_CT_FIXED) begin
                            c_d.wr  = lad_s[`LFP_CT_DIR_BIT];
                            c_d.cnt = 3'h0;
                            c_d.st  = lfp_pkg::ST_ADDR;
                        end else begin
                            c_d.st = lfp_pkg::ST_SKIP;
                        end
                    end
                    lfp_pkg::ST_ADDR: begin
                        c_d.addr = addr_nx;
                        c_d.cnt  = c_q.cnt + 3'h1;
                        if (c_q.cnt == `LFP_ADDR_LAST) begin
                            if (!(&addr_nx[`LFP_A_ONES_MSB:`LFP_A_ONES_LSB])) begin
                                c_d.st = lfp_pkg::ST_SKIP;
                            end else if (c_q.wr) begin
                                c_d.st = lfp_pkg::ST_WDLO;
                            end else begin
                                c_d.rd_req = 1'b1;
                                c_d.st     = lfp_pkg::ST_RTAR1;
                            end
                        end
                    end
                    lfp_pkg::ST_RTAR1: begin
                        c_d.st = lfp_pkg::ST_RTAR2;
                    end
                    lfp_pkg::ST_RTAR2: begin
                        c_d.cnt = 3'h0;
                        c_d.st  = lfp_pkg::ST_WAIT;
                    end
                    lfp_pkg::ST_WAIT: begin
                        c_d.cnt = c_q.cnt + 3'h1;
                        if (c_q.cnt == `LFP_WAIT_LAST) begin
                            c_d.st = lfp_pkg::ST_RDY;
                        end
                    end
                    lfp_pkg::ST_RDY: begin
                        c_d.data = rd_data;
                        c_d.st   = lfp_pkg::ST_DLO;
                    end
                    lfp_pkg::ST_DLO: begin
                        c_d.st = lfp_pkg::ST_DHI;
                    end
                    lfp_pkg::ST_DHI: begin
                        c_d.st = lfp_pkg::ST_TEND;
                    end
                    lfp_pkg::ST_WDLO: begin
                        c_d.data[3:0] = lad_s;
                        c_d.st        = lfp_pkg::ST_WDHI;
                    end
                    lfp_pkg::ST_WDHI: begin
                        // Command leaves now; a later abort only frees the bus
                        c_d.data[7:4] = lad_s;
                        c_d.cmd_stb   = 1'b1;
                        c_d.st        = lfp_pkg::ST_WTAR1;
                    end
                    lfp_pkg::ST_WTAR1: begin
                        c_d.st = lfp_pkg::ST_WTAR2;
                    end
                    lfp_pkg::ST_WTAR2: begin
                        c_d.st = lfp_pkg::ST_WACK;
                    end
                    lfp_pkg::ST_WACK: begin
                        c_d.st = lfp_pkg::ST_TEND;
                    end
                    lfp_pkg::ST_TEND: begin
                        c_d.st = lfp_pkg::ST_IDLE;
                    end
                endcase
            end

            // Line drive for the LPC clock now starting
            c_d.lad_oe  = 1'b1;
            c_d.lad_out = `LFP_NIB_TAR;
            unique case (c_d.st)
                lfp_pkg::ST_RTAR2, lfp_pkg::ST_WTAR2, lfp_pkg::ST_TEND: begin
                    c_d.lad_out = `LFP_NIB_TAR;
                end
                lfp_pkg::ST_WAIT: begin
                    c_d.lad_out = `LFP_SHORT_WAIT;
                end
                lfp_pkg::ST_RDY: begin
                    c_d.lad_out = `LFP_READY_SYNC;
                end
                lfp_pkg::ST_WACK: begin
                    c_d.lad_out = `LFP_WRITE_ACK;
                end
                lfp_pkg::ST_DLO: begin
                    c_d.lad_out = c_d.data[3:0];
                end
                lfp_pkg::ST_DHI: begin
                    c_d.lad_out = c_d.data[7:4];
                end
                default: begin
                    c_d.lad_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and write command path

    assign lad_out  = c_q.lad_out;
    assign lad_oe   = c_q.lad_oe;
    assign rd_req   = c_q.rd_req;
    assign rd_array = c_q.addr[`LFP_A_ARRAY];
    assign rd_addr  = c_q.addr[18:0];
    assign in_reset = dev_rst;

    lfp_cmd_if cmd ();

    assign cmd.stb   = c_q.cmd_stb;
    assign cmd.array = c_q.addr[`LFP_A_ARRAY];
    assign cmd.addr  = c_q.addr[18:0];
    assign cmd.data  = c_q.data;

    lfp_guard u_guard (
        .clk                          (clk),
        .rst                          (rst),
        .dev_rst                      (dev_rst),
        .top_block_lock_n             (tbl_n_s),
        .main_block_protect_n         (wp_n_s),
        .program_supply_lockout_level (vpp_s),
        .pe_busy                      (pe_busy),
        .err_clear                    (err_clear),
        .cmd                          (cmd),
        .pe_cmd_valid                 (pe_cmd_valid),
        .pe_cmd_array                 (pe_cmd_array),
        .pe_cmd_addr                  (pe_cmd_addr),
        .pe_cmd_data                  (pe_cmd_data),
        .pe_abort                     (pe_abort),
        .supply_err                   (supply_err),
        .lock_bits                    (lock_bits)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    sequence s_step(lfp_pkg::lfp_state_t s);
        adv && frame_n_s && c_q.st == s;
    endsequence

    sequence s_drive(logic [3:0] v);
        c_q.lad_oe && c_q.lad_out == v;
    endsequence

    chk_start_claim: assert property (
        (adv && !frame_n_s && lad_s != `LFP_NIB_START) |=> (c_q.st == lfp_pkg::ST_SKIP && !c_q.lad_oe))
        else $error("bad start nibble was claimed");

    chk_ctype_check: assert property (
        (s_step(lfp_pkg::ST_CTYPE) and (lad_s[3:2] != `LFP_CT_FIXED)) |=> c_q.st == lfp_pkg::ST_SKIP)
        else $error("bad cycle type was accepted");

    chk_addr_ones: assert property (
        (s_step(lfp_pkg::ST_ADDR) and (c_q.cnt == `LFP_ADDR_LAST)
         and !(&addr_nx[`LFP_A_ONES_MSB:`LFP_A_ONES_LSB])) |=> (c_q.st == lfp_pkg::ST_SKIP && !rd_req))
        else $error("address without upper ones was accepted");

    chk_read_take: assert property (
        s_step(lfp_pkg::ST_RTAR1) |=> s_drive(`LFP_NIB_TAR))
        else $error("device did not take lines on turnaround");

    chk_wait_sync: assert property (
        s_step(lfp_pkg::ST_RTAR2) |=> (s_drive(`LFP_SHORT_WAIT) and (c_q.cnt == 3'h0)))
        else $error("short wait sync missing");

    chk_ready_sync: assert property (
        (s_step(lfp_pkg::ST_WAIT) and (c_q.cnt == `LFP_WAIT_LAST)) |=> s_drive(`LFP_READY_SYNC))
        else $error("ready sync not after two waits");

    chk_data_order: assert property (
        (s_step(lfp_pkg::ST_RDY) ##1 (c_q.st == lfp_pkg::ST_DLO)) |-> s_drive($past(rd_data[3:0], 1)))
        else $error("low nibble not first");

    chk_read_float: assert property (
        s_step(lfp_pkg::ST_TEND) |=> (!c_q.lad_oe && c_q.st == lfp_pkg::ST_IDLE))
        else $error("lines not floated on final turnaround");

    chk_write_ack: assert property (
        s_step(lfp_pkg::ST_WTAR2) |=> s_drive(`LFP_WRITE_ACK))
        else $error("write ack sync missing");

    chk_abort_float: assert property (
        (adv && !frame_n_s) |=> !c_q.lad_oe)
        else $error("abort did not float lines");

    chk_write_issue: assert property (
        s_step(lfp_pkg::ST_WDHI) |=> (cmd.stb && cmd.data[7:4] == $past(lad_s)))
        else $error("write command not issued at last nibble");

    chk_reset_float: assert property (
        dev_rst |=> (!c_q.lad_oe && c_q.st == lfp_pkg::ST_IDLE))
        else $error("lines driven during reset");

endmodule

/* inc/lfp_cfg.svh */
/*
 * Constants of the LPC flash target port: nibble codes, field positions,
 * counts and reset values. Assumes inclusion by bare name from every file.
 */
`ifndef LFP_CFG_SVH
`define LFP_CFG_SVH

`define LFP_NIB_START    4'h0
`define LFP_NIB_TAR      4'hF
`define LFP_SHORT_WAIT   4'h5
`define LFP_READY_SYNC   4'h0
`define LFP_WRITE_ACK    4'h0
`define LFP_CT_FIXED     2'h1
`define LFP_CT_DIR_BIT   1
`define LFP_WAIT_LAST    3'h1
`define LFP_ADDR_LAST    3'h7
`define LFP_A_ARRAY      22
`define LFP_A_ONES_MSB   31
`define LFP_A_ONES_LSB   23
`define LFP_BLK_MSB      18
`define LFP_BLK_LSB      16
`define LFP_TOP_BLK      3'h7
`define LFP_LOCK_RST     8'h00
`define LFP_LOCK_OFS     8'h02
`endif

/* inc/lfp_pkg.sv */
/*
 * Types of the LPC flash target port: cycle states and state records.
 * Assumes the constants header is compiled alongside.
 */
package lfp_pkg;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SKIP, ST_CTYPE, ST_ADDR, ST_RTAR1, ST_RTAR2, ST_WAIT, ST_RDY,
        ST_DLO, ST_DHI, ST_WDLO, ST_WDHI, ST_WTAR1, ST_WTAR2, ST_WACK, ST_TEND
    } lfp_state_t;

    typedef struct packed {
        lfp_state_t  st;
        logic [2:0]  cnt;
        logic        wr;
        logic [31:0] addr;
        logic [7:0]  data;
        logic [3:0]  lad_out;
        logic        lad_oe;
        logic        rd_req;
        logic        cmd_stb;
    } lfp_core_t;

    typedef struct packed {
        logic [7:0]  lock;
        logic        err;
        logic        valid;
        logic        array;
        logic [18:0] addr;
        logic [7:0]  data;
        logic        abort;
    } lfp_guard_t;

endpackage

/* inc/lfp_cmd_if.sv */
/*
 * Write command path from the bus port to the protection guard.
 * Assumes both ends run on the same clock; stb is a one-cycle pulse.
 */
interface lfp_cmd_if;
    logic        stb;
    logic        array;
    logic [18:0] addr;
    logic [7:0]  data;
    modport port  (output stb, array, addr, data);
    modport guard (input  stb, array, addr, data);
endinterface

/* src/lfp_sync.sv */
/*
 * Two-flop synchroniser for a bundle of pin inputs.
 * Assumes each bit is an independent level; bundles are not coherent.
 */
module lfp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [1:0][W-1:0] s_q;
    logic [1:0][W-1:0] s_d;

    always_comb begin
        s_d[0] = d;
        s_d[1] = s_q[0];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q[1];

endmodule

/* src/lfp_guard.sv */
/*
 * Protection guard: lock registers, hardware protect inputs, supply lockout
 * and abort of program/erase on reset. Assumes dev_rst and the protect
 * inputs are already synchronised to clk.
 */
`include "lfp_cfg.svh"

module lfp_guard (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        dev_rst,
    input  wire logic        top_block_lock_n,
    input  wire logic        main_block_protect_n,
    input  wire logic        program_supply_lockout_level,
    input  wire logic        pe_busy,
    input  wire logic        err_clear,
    lfp_cmd_if.guard         cmd,
    output logic             pe_cmd_valid,
    output logic             pe_cmd_array,
    output logic      [18:0] pe_cmd_addr,
    output logic      [7:0]  pe_cmd_data,
    output logic             pe_abort,
    output logic             supply_err,
    output logic      [7:0]  lock_bits
);

    lfp_pkg::lfp_guard_t g_q;
    lfp_pkg::lfp_guard_t g_d;
    logic [2:0]          blk;
    logic                hw_ok;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        blk     = cmd.addr[`LFP_BLK_MSB:`LFP_BLK_LSB];
        hw_ok   = (blk == `LFP_TOP_BLK) ? top_block_lock_n : main_block_protect_n;
        g_d       = g_q;
        g_d.valid = 1'b0;
        g_d.abort = dev_rst & pe_busy;
        if (err_clear) begin
            g_d.err = 1'b0;
        end
        if (dev_rst) begin
            g_d.lock = `LFP_LOCK_RST;
            g_d.err  = 1'b0;
        end else if (cmd.stb) begin
            if (!cmd.array) begin
                if (cmd.addr[7:0] == `LFP_LOCK_OFS) begin
                    g_d.lock[blk] = cmd.data[0];
                end
            end else if (program_supply_lockout_level) begin
                // Set after the clear so a refusal is never lost
                g_d.err = 1'b1;
            end else if (hw_ok && !g_q.lock[blk]) begin
                g_d.valid = 1'b1;
                g_d.array = cmd.array;
                g_d.addr  = cmd.addr;
                g_d.data  = cmd.data;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            g_q <= '0;
        end else begin
            g_q <= g_d;
        end
    end

    assign pe_cmd_valid = g_q.valid;
    assign pe_cmd_array = g_q.array;
    assign pe_cmd_addr  = g_q.addr;
    assign pe_cmd_data  = g_q.data;
    assign pe_abort     = g_q.abort;
    assign supply_err   = g_q.err;
    assign lock_bits    = g_q.lock;

    ////////////////////////////////////////////////////////////////////////
    chk_supply_refuse: assert property (@(posedge clk) disable iff (rst)
        (cmd.stb && cmd.array && program_supply_lockout_level && !dev_rst) |=> (g_q.err && !g_q.valid))
        else $error("supply lockout did not refuse");
    chk_top_lock: assert property (@(posedge clk) disable iff (rst)
        (cmd.stb && blk == `LFP_TOP_BLK && !top_block_lock_n) |=> !g_q.valid)
        else $error("top block write passed while locked");
    chk_main_protect: assert property (@(posedge clk) disable iff (rst)
        (cmd.stb && blk != `LFP_TOP_BLK && !main_block_protect_n) |=> !g_q.valid)
        else $error("main block write passed while protected");
    chk_reset_abort: assert property (@(posedge clk) disable iff (rst)
        (dev_rst && pe_busy) |=> g_q.abort)
        else $error("reset did not abort program or erase");

endmodule

/* tb/lfp_host_model.sv */
/*
 * Bus master model for the flash bus port: makes the free-running bus clock
 * and sends nibbles one bus cycle at a time.
 * Assumes the bench resolves the shared nibble wire and passes it back in.
 */
module lfp_host_model (
    input  wire logic       clk,
    input  wire logic [3:0] lad_wire,
    input  wire logic       dev_oe,
    output logic            lpc_clk,
    output logic            lframe_n,
    output logic [3:0]      lad,
    output logic            lad_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ph;
    logic [3:0] lad_seen;
    logic       oe_seen;
    initial begin
        ph = 3'h0;
        lpc_clk = 1'b0;
        lframe_n = 1'b1;
        lad = 4'hF;
        lad_en = 1'b0;
    end
    ////////////////////////////////////////
    // Six fast cycles per half period keeps the port's edge detector fed
    always @(posedge clk) begin
        if (ph == 3'h5) begin
            ph <= 3'h0;
            lpc_clk <= ~lpc_clk;
        end else begin
            ph <= ph + 3'h1;
        end
    end
    // Lines change after the falling edge, so they are settled at the rise
    task automatic cyc(input logic fr, input logic en, input logic [3:0] nib);
        @(negedge lpc_clk);
        lframe_n <= fr;
        lad_en <= en;
        lad <= nib;
        @(posedge lpc_clk);
        lad_seen = lad_wire;
        oe_seen = dev_oe;
    endtask
    task automatic send(input logic [3:0] st, input logic [3:0] typ, input logic [31:0] a);
        int i;
        cyc(1'b0, 1'b1, st);
        cyc(1'b1, 1'b1, typ);
        for (i = 7; i >= 0; i--) cyc(1'b1, 1'b1, a[i*4 +: 4]);
    endtask
endmodule

/* tb/tb_top.sv */
/*
 * Self-checking bench of the flash bus port: reads, writes, protection,
 * abort and resets. Assumes the host model drives the bus side.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, ifr_n, cpr_n, tbl_n, mbp_n, vlow, busy, eclr;
    logic [7:0]  rd_data, cmd_data, lock_bits;
    logic [3:0]  lad_out, lad_wire, h_lad;
    logic        lad_oe, h_en, lpc_clk, lframe_n, rd_req, rd_array;
    logic        cmd_v, cmd_arr, pe_abort, supply_err, in_reset;
    logic [18:0] rd_addr, cmd_addr;
    logic [27:0] cmd_seen;
    int          failures, comparisons, cmd_cnt;
    // Pull-ups hold released lines high
    assign lad_wire = lad_oe ? lad_out : (h_en ? h_lad : 4'hF);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rd_req) rd_data <= rd_addr[7:0] ^ 8'h5A;
        if (cmd_v) begin
            cmd_cnt++;
            cmd_seen <= {cmd_arr, cmd_data, cmd_addr};
        end
    end
    lfp_host_model host (.clk(clk), .lad_wire(lad_wire), .dev_oe(lad_oe), .lpc_clk(lpc_clk),
        .lframe_n(lframe_n), .lad(h_lad), .lad_en(h_en));
    lfp_target dut (.clk(clk), .rst(rst), .lpc_clk(lpc_clk), .lframe_n(lframe_n), .lad_in(lad_wire),
        .lad_out(lad_out), .lad_oe(lad_oe), .interface_reset_n(ifr_n), .cpu_reset_n(cpr_n),
        .top_block_lock_n(tbl_n), .main_block_protect_n(mbp_n), .program_supply_lockout_level(vlow),
        .rd_req(rd_req), .rd_array(rd_array), .rd_addr(rd_addr), .rd_data(rd_data), .pe_busy(busy),
        .err_clear(eclr), .pe_cmd_valid(cmd_v), .pe_cmd_array(cmd_arr), .pe_cmd_addr(cmd_addr),
        .pe_cmd_data(cmd_data), .pe_abort(pe_abort), .supply_err(supply_err), .lock_bits(lock_bits),
        .in_reset(in_reset));
    ////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic settle;
        int n;
        for (n = 0; n < 20 && in_reset !== 1'b0; n++) @(posedge clk);
        if (in_reset !== 1'b0) begin
            failures++;
            wrap_up;
        end
        repeat (4) @(posedge clk);
    endtask
    function automatic logic [3:0] rd_nib(int c, logic [7:0] d);
        case (c)
            13, 14: return 4'h5;
            15: return 4'h0;
            16: return d[3:0];
            17: return d[7:4];
            default: return 4'hF;
        endcase
    endfunction
    task automatic t_read(input logic [31:0] a);
        int c;
        host.send(4'h0, 4'h4, a);
        for (c = 11; c <= 19; c++) begin
            host.cyc(1'b1, c == 11, 4'hF);
            chk("read oe", host.oe_seen, c >= 12 && c <= 18);
            if (c >= 12 && c <= 18) chk("read lad", host.lad_seen, rd_nib(c, a[7:0] ^ 8'h5A));
        end
        chk("read addr", {rd_array, rd_addr}, {a[22], a[18:0]});
        $display("test read %h done", a);
    endtask
    task automatic t_write(input logic [3:0] typ, input logic [31:0] a, input logic [7:0] d, input logic ok);
        int c;
        cmd_cnt = 0;
        host.send(4'h0, typ, a);
        host.cyc(1'b1, 1'b1, d[3:0]);
        host.cyc(1'b1, 1'b1, d[7:4]);
        for (c = 13; c <= 17; c++) begin
            host.cyc(1'b1, c == 13, 4'hF);
            chk("write oe", host.oe_seen, c >= 14 && c <= 16);
            if (c >= 14 && c <= 16) chk("write lad", host.lad_seen, c == 15 ? 4'h0 : 4'hF);
        end
        chk("cmd count", cmd_cnt, ok);
        if (ok) chk("cmd", cmd_seen, {a[22], d, a[18:0]});
        $display("test write %h done", a);
    endtask
    task automatic t_ignore(input logic [3:0] st, input logic [3:0] typ, input logic [31:0] a);
        int c;
        host.send(st, typ, a);
        for (c = 11; c <= 19; c++) begin
            host.cyc(1'b1, c == 11, 4'hF);
            chk("ignored oe", host.oe_seen, 1'b0);
        end
        $display("test ignore %h done", st);
    endtask
    task automatic t_abort;
        int c;
        host.send(4'h0, 4'h4, 32'hFFC0_0011);
        host.cyc(1'b1, 1'b1, 4'hF);
        host.cyc(1'b1, 1'b0, 4'hF);
        host.cyc(1'b0, 1'b1, 4'hF);
        chk("wait sync", host.lad_seen, 4'h5);
        for (c = 0; c < 4; c++) begin
            host.cyc(1'b1, 1'b0, 4'hF);
            chk("abort oe", host.oe_seen, 1'b0);
        end
        $display("test abort done");
    endtask
    task automatic t_protect;
        @(posedge clk) tbl_n <= 1'b0;
        t_write(4'h6, 32'hFFC7_0010, 8'h3C, 1'b0);
        t_write(4'h7, 32'hFFC3_0020, 8'hA5, 1'b1);
        @(posedge clk) {tbl_n, mbp_n} <= 2'b10;
        t_write(4'h6, 32'hFFC3_0020, 8'hA5, 1'b0);
        t_write(4'h6, 32'hFFC7_0010, 8'h3C, 1'b1);
        @(posedge clk) {mbp_n, vlow} <= 2'b11;
        t_write(4'h6, 32'hFFC1_0030, 8'h11, 1'b0);
        chk("supply err", supply_err, 1'b1);
        @(posedge clk) {vlow, eclr} <= 2'b01;
        @(posedge clk) eclr <= 1'b0;
        repeat (2) @(posedge clk);
        chk("err cleared", supply_err, 1'b0);
        $display("test protect done");
    endtask
    task automatic t_reset;
        t_write(4'h6, 32'hFF82_0002, 8'h01, 1'b0);
        chk("lock set", lock_bits, 8'h04);
        t_write(4'h6, 32'hFFC2_0000, 8'h77, 1'b0);
        @(posedge clk) {busy, ifr_n} <= 2'b10;
        repeat (5) @(posedge clk);
        chk("pin reset", {in_reset, lad_oe, pe_abort}, 3'b101);
        {busy, ifr_n} <= 2'b01;
        settle;
        chk("lock default", lock_bits, 8'h00);
        @(posedge clk) cpr_n <= 1'b0;
        repeat (5) @(posedge clk);
        chk("cpu reset", {in_reset, lad_oe}, 2'b10);
        cpr_n <= 1'b1;
        settle;
        t_read(32'hFFC5_0042);
        $display("test reset done");
    endtask
    initial begin
        {rst, ifr_n, cpr_n, tbl_n, mbp_n, vlow, busy, eclr} = 8'hF8;
        {rd_data, failures, comparisons, cmd_cnt} = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle;
        t_read(32'hFFC7_FFA3);
        t_read(32'hFF80_001C);
        t_ignore(4'h1, 4'h4, 32'hFFC0_0000);
        t_ignore(4'h0, 4'h8, 32'hFFC0_0000);
        t_ignore(4'h0, 4'h4, 32'hFF40_0000);
        t_abort;
        t_protect;
        t_reset;
        wrap_up;
    end
    initial begin
        #100000;
        failures++;
        wrap_up;
    end
endmodule
